// File: src/asspi_map.svh
// asspi_map.svh: opcodes, offsets, field positions and timing counts
// assumes: included by the angle sensor spi block files, 50 MHz sys_clk
`ifndef ASSPI_MAP_SVH
`define ASSPI_MAP_SVH

// -------------------------------------------------------------------------
// opcodes in frame bits 15:13
// -------------------------------------------------------------------------
`define ASSPI_OP_ANGLE 3'h0
`define ASSPI_OP_CLEAR 3'h1
`define ASSPI_OP_READ 3'h2
`define ASSPI_OP_WRITE 3'h4
`define ASSPI_OP_RESTORE 3'h5
`define ASSPI_OP_STORE_ALL 3'h6
`define ASSPI_OP_STORE_ONE 3'h7

// -------------------------------------------------------------------------
// register offsets and fields
// -------------------------------------------------------------------------
`define ASSPI_REG_DIR 5'h09
`define ASSPI_REG_FIELD 5'h1B
`define ASSPI_DIR_BIT 7
`define ASSPI_FLAG_HIGH_BIT 7
`define ASSPI_FLAG_LOW_BIT 6
`define ASSPI_NUM_REGS 32
`define ASSPI_FRAME_BITS 16

// -------------------------------------------------------------------------
// timing: figures as printed, counts derived from the 50 MHz clock
// -------------------------------------------------------------------------
`define ASSPI_CLK_MHZ 50
`define ASSPI_REFRESH_US 1
`define ASSPI_REFRESH_CYC (`ASSPI_REFRESH_US * `ASSPI_CLK_MHZ)
`define ASSPI_STORE_ONE_MS 23
`define ASSPI_STORE_ALL_MS 704
`define ASSPI_RESTORE_US 240
`define ASSPI_STORE_ONE_CYC (`ASSPI_STORE_ONE_MS * 1000 * `ASSPI_CLK_MHZ)
`define ASSPI_STORE_ALL_CYC (`ASSPI_STORE_ALL_MS * 1000 * `ASSPI_CLK_MHZ)
`define ASSPI_RESTORE_CYC (`ASSPI_RESTORE_US * `ASSPI_CLK_MHZ)

`endif

// File: src/asspi_nvm.sv
// asspi_nvm.sv: nonvolatile store and restore engine with busy timing
// assumes: start pulses only while busy is low; the register file copies
`timescale 1ns/1ns
`include "asspi_map.svh"
module asspi_nvm import asspi_pkg::*; #(
    parameter int unsigned STORE_ONE_CYC = `ASSPI_STORE_ONE_CYC,
    parameter int unsigned STORE_ALL_CYC = `ASSPI_STORE_ALL_CYC,
    parameter int unsigned RESTORE_CYC = `ASSPI_RESTORE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire asspi_nvreq_s req,
    output logic busy,
    output logic done_pulse,
    output asspi_nvop_e done_op,
    output logic [4:0] done_addr
);
    asspi_nv_e state;
    logic [31:0] count;
    asspi_nvop_e op;
    logic [4:0] addr;
    logic [31:0] load_cyc;

    // busy duration per kind of operation
    assign load_cyc = (req.op == ASSPI_NVOP_ONE) ? STORE_ONE_CYC :
        (req.op == ASSPI_NVOP_ALL) ? STORE_ALL_CYC : RESTORE_CYC;

    // operation runs full length; copy is committed at its end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ASSPI_NV_IDLE;
            count <= 32'h0;
            op <= ASSPI_NVOP_ONE;
            addr <= 5'h00;
            busy <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            case (state)
                ASSPI_NV_IDLE: begin
                    if (req.start) begin
                        state <= ASSPI_NV_RUN;
                        count <= load_cyc - 32'h1;
                        op <= req.op;
                        addr <= req.addr;
                        busy <= 1'b1;
                    end
                end
                ASSPI_NV_RUN: begin
                    if (count == 32'h0) begin
                        state <= ASSPI_NV_DONE;
                        done_pulse <= 1'b1;
                    end else begin
                        count <= count - 32'h1;
                    end
                end
                ASSPI_NV_DONE: begin
                    state <= ASSPI_NV_IDLE;
                    busy <= 1'b0;
                end
                default: state <= ASSPI_NV_IDLE;
            endcase
        end
    end
    assign done_op = op;
    assign done_addr = addr;

    AST_BUSY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.start && !busy |=> busy [*2])
        else $error("busy not raised on start");
endmodule : asspi_nvm

// File: src/asspi_pkg.sv
// asspi_pkg.sv: types shared by the angle sensor spi command block
// assumes: constants come from asspi_map.svh
package asspi_pkg;

    // nonvolatile engine states, gray along idle-run-done
    typedef enum logic [1:0] {
        ASSPI_NV_IDLE = 2'b00,
        ASSPI_NV_RUN = 2'b01,
        ASSPI_NV_DONE = 2'b11
    } asspi_nv_e;

    typedef enum logic [1:0] {
        ASSPI_NVOP_ONE = 2'b00,
        ASSPI_NVOP_ALL = 2'b01,
        ASSPI_NVOP_RESTORE = 2'b10
    } asspi_nvop_e;

    // decoded request frame
    typedef struct packed {
        logic [2:0] op;
        logic [4:0] addr;
        logic [7:0] data;
    } asspi_frame_s;

    // nonvolatile request towards the memory engine
    typedef struct packed {
        logic start;
        asspi_nvop_e op;
        logic [4:0] addr;
    } asspi_nvreq_s;

endpackage : asspi_pkg

// File: src/asspi_top.sv
// asspi_top.sv: spi slave command logic of a magnetic angle sensor
// assumes: spi pins are asynchronous to sys_clk and sampled here; mode 0/3
// Function
// - load new angle sample every microsecond
// - chip select fall freezes output buffer
// - chip select rise releases output buffer
// - sixteen clocks shift angle out msb first
// - fast repeated reads return same angle word
// - read request: opcode 010, five-bit address
// - read reply: angle high byte, register value
// - register 27 reports high and low field
// - write request: opcode 100, address, data
// - write reply echoes written value with angle; register 27 returns its flags
// - direction bit one reverses angle sense
// - startup copies nonvolatile memory into registers
// - restore-all reloads registers from memory
// - store-single saves addressed register
// - store-all saves every register
// - commands ignored while memory busy
// - busy pin high during memory operation
// - store-single is opcode 111 with address
// - store-all is opcode 110
// - restore-all is opcode 101
// - memory operations last 23ms, 704ms, 240us
`timescale 1ns/1ns
`include "asspi_map.svh"
module asspi_top import asspi_pkg::*; #(
    parameter int unsigned STORE_ONE_CYC = `ASSPI_STORE_ONE_CYC,
    parameter int unsigned STORE_ALL_CYC = `ASSPI_STORE_ALL_CYC,
    parameter int unsigned RESTORE_CYC = `ASSPI_RESTORE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic [15:0] angle_in,
    input wire logic field_high_flag,
    input wire logic field_low_flag,
    output logic nvm_busy,
    output logic dir_ccw
);
    // ---------------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------------
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic [1:0] fh_sync;
    logic [1:0] fl_sync;
    logic sclk_q;
    logic cs_q;

    // two flops each; only stage 1 is read by logic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            mosi_sync <= 2'h0;
            fh_sync <= 2'h0;
            fl_sync <= 2'h0;
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk};
            cs_sync <= {cs_sync[0], cs_n};
            mosi_sync <= {mosi_sync[0], mosi};
            fh_sync <= {fh_sync[0], field_high_flag};
            fl_sync <= {fl_sync[0], field_low_flag};
            sclk_q <= sclk_sync[1];
            cs_q <= cs_sync[1];
        end
    end

    // edge detects on the settled copies
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic active;
    assign cs_fall = cs_q && !cs_sync[1];
    assign cs_rise = !cs_q && cs_sync[1];
    assign sclk_rise = !sclk_q && sclk_sync[1];
    assign sclk_fall = sclk_q && !sclk_sync[1];
    assign active = !cs_sync[1];

    // ---------------------------------------------------------------------
    // angle sampling and freeze
    // ---------------------------------------------------------------------
    logic [5:0] refresh_cnt;
    logic [15:0] angle_buf;
    logic frozen;
    logic [15:0] angle_dir;

    // direction bit mirrors the angle about zero
    assign angle_dir = dir_ccw ? (16'h0 - angle_in) : angle_in;

    // buffer refreshes on the tick only while not frozen
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_cnt <= 6'h00;
            angle_buf <= 16'h0000;
            frozen <= 1'b0;
        end else begin
            if (refresh_cnt == 6'(`ASSPI_REFRESH_CYC - 1)) begin
                refresh_cnt <= 6'h00;
            end else begin
                refresh_cnt <= refresh_cnt + 6'h01;
            end
            if (cs_fall) begin
                frozen <= 1'b1;
            end else if (cs_rise) begin
                frozen <= 1'b0;
            end
            // stale word kept between ticks
            if (!frozen && !cs_fall && refresh_cnt == 6'h00) begin
                angle_buf <= angle_dir;
            end
        end
    end

    // ---------------------------------------------------------------------
    // frame shifter
    // ---------------------------------------------------------------------
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [4:0] bit_cnt;
    logic frame_done;
    logic [15:0] next_tx;
    logic reply_reg;
    logic [7:0] reply_val;

    // second frame of read or write carries angle byte and register byte
    assign next_tx = reply_reg ? {angle_buf[15:8], reply_val} : angle_buf;

    // capture on rising, shift out on falling; frame counted to sixteen
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
            bit_cnt <= 5'h00;
            frame_done <= 1'b0;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            miso_oe <= active;
            if (cs_fall) begin
                tx_shift <= {next_tx[14:0], 1'b0};
                miso <= next_tx[15];
                bit_cnt <= 5'h00;
            end else if (active && sclk_rise) begin
                rx_shift <= {rx_shift[14:0], mosi_sync[1]};
                bit_cnt <= bit_cnt + 5'h01;
                // early chip select rise just drops the frame
                if (bit_cnt == 5'(`ASSPI_FRAME_BITS - 1)) begin
                    frame_done <= 1'b1;
                end
            end else if (active && sclk_fall && bit_cnt != 5'h00) begin
                miso <= tx_shift[15];
                tx_shift <= {tx_shift[14:0], 1'b0};
            end
        end
    end

    // ---------------------------------------------------------------------
    // register file and command decode
    // ---------------------------------------------------------------------
    logic [7:0] regs [0:`ASSPI_NUM_REGS-1];
    // blank image reads as zero, so the start-up copy never loads unknowns
    logic [7:0] nv_mem [0:`ASSPI_NUM_REGS-1] = '{default: 8'h00};
    asspi_frame_s frame;
    asspi_nvreq_s nvreq;
    logic nv_done;
    asspi_nvop_e nv_done_op;
    logic [4:0] nv_done_addr;
    logic boot_load;
    logic [7:0] flag_byte;

    assign frame = asspi_frame_s'(rx_shift);
    assign flag_byte = {fh_sync[1], fl_sync[1], 6'h00};

    // read port: field register is live, others from storage
    function automatic logic [7:0] rd_val(input logic [4:0] a, input logic [7:0] r,
        input logic [7:0] f);
        rd_val = (a == `ASSPI_REG_FIELD) ? f : r;
    endfunction : rd_val

    // nonvolatile request only when not busy
    assign nvreq.start = frame_done && !nvm_busy && frame.op[2] && frame.op[0] |
        (frame_done && !nvm_busy && frame.op == `ASSPI_OP_STORE_ALL);
    assign nvreq.op = (frame.op == `ASSPI_OP_STORE_ONE) ? ASSPI_NVOP_ONE :
        (frame.op == `ASSPI_OP_STORE_ALL) ? ASSPI_NVOP_ALL :
        ASSPI_NVOP_RESTORE;
    assign nvreq.addr = frame.addr;

    asspi_nvm #(
        .STORE_ONE_CYC(STORE_ONE_CYC),
        .STORE_ALL_CYC(STORE_ALL_CYC),
        .RESTORE_CYC(RESTORE_CYC)
    ) u_nvm (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(nvreq),
        .busy(nvm_busy),
        .done_pulse(nv_done),
        .done_op(nv_done_op),
        .done_addr(nv_done_addr)
    );

    // read and write replies and the start-up load flag; memory holds no reset,
    // so its power-up content is whatever the array starts with
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reply_reg <= 1'b0;
            reply_val <= 8'h00;
            boot_load <= 1'b1;
        end else begin
            boot_load <= 1'b0;
            if (frame_done) begin
                reply_reg <= 1'b0;
                if (!nvm_busy && frame.op == `ASSPI_OP_READ) begin
                    reply_reg <= 1'b1; // low byte ignored
                    reply_val <= rd_val(frame.addr, regs[frame.addr], flag_byte);
                end else if (!nvm_busy && frame.op == `ASSPI_OP_WRITE) begin
                    reply_reg <= 1'b1;
                    reply_val <= rd_val(frame.addr, frame.data, flag_byte);
                end
            end
        end
    end

    // storage arrays, no reset so they map onto plain memory
    genvar gi;
    generate
        for (gi = 0; gi < `ASSPI_NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge sys_clk) begin
                if (boot_load || (nv_done && nv_done_op == ASSPI_NVOP_RESTORE)) begin
                    regs[gi] <= nv_mem[gi];
                end else if (frame_done && !nvm_busy && frame.op == `ASSPI_OP_WRITE
                    && frame.addr == 5'(gi)) begin
                    regs[gi] <= frame.data;
                end
                if (nv_done && (nv_done_op == ASSPI_NVOP_ALL ||
                    (nv_done_op == ASSPI_NVOP_ONE && nv_done_addr == 5'(gi)))) begin
                    nv_mem[gi] <= regs[gi];
                end
            end
        end
    endgenerate

    // direction output registered from the config bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_ccw <= 1'b0;
        end else begin
            dir_ccw <= regs[`ASSPI_REG_DIR][`ASSPI_DIR_BIT];
        end
    end

    // ---------------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------------
    AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frozen && !cs_rise |=> $stable(angle_buf))
        else $error("angle buffer moved while frozen");
    AST_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cs_rise |=> !frozen)
        else $error("buffer not released on cs rise");
    AST_REFRESH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !frozen && !cs_fall && refresh_cnt == 6'h00 |=> angle_buf == $past(angle_dir))
        else $error("angle not refreshed on tick");
    AST_BUSY_IGNORE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done && nvm_busy |=> !reply_reg)
        else $error("command acted on while busy");
    AST_READ_REPLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done && !nvm_busy && frame.op == `ASSPI_OP_READ |=> reply_reg)
        else $error("read request not answered");
    AST_WRITE_ECHO: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done && !nvm_busy && frame.op == `ASSPI_OP_WRITE
        && frame.addr != `ASSPI_REG_FIELD |=> reply_val == $past(frame.data))
        else $error("write echo wrong");
    AST_DECODE_16: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done |-> $past(bit_cnt) == 5'h0F)
        else $error("frame decoded early");
    AST_BUSY_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
        nvreq.start |=> nvm_busy)
        else $error("busy not raised");
    COV_READ: cover property (@(posedge sys_clk) frame_done && frame.op == `ASSPI_OP_READ);
    COV_WRITE: cover property (@(posedge sys_clk) frame_done && frame.op == `ASSPI_OP_WRITE);
    COV_STORE: cover property (@(posedge sys_clk) nvreq.start);
    COV_BUSY_DROP: cover property (@(posedge sys_clk) frame_done && nvm_busy);
endmodule : asspi_top

// File: tb/asspi_master_model.sv
// asspi_master_model.sv: spi master model facing the angle sensor block
// assumes: mode 0, sclk of 160 ns built from the 50 MHz sys_clk
`timescale 1ns/1ns
module asspi_master_model (
    input wire logic sys_clk,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    // ---------------------------------------------------------------
    // idle: clock parked low (pull-down), select high
    // ---------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // one frame, msb first; fewer than 16 bits ends a read early
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        repeat (60) @(posedge sys_clk); // lets the 1 us refresh land first
        cs_n <= 1'b0;
        repeat (4) @(posedge sys_clk); // first bit lags select by a few clocks
        for (int i = 0; i < nbits; i++) begin
            mosi <= tx[15 - i];
            repeat (4) @(posedge sys_clk);
            rx = {rx[14:0], miso};
            sclk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi; // released line must not keep its last value
        repeat (10) @(posedge sys_clk);
    endtask : xfer
endmodule : asspi_master_model

// File: tb/testbench.sv
// testbench.sv: self-checking bench for the angle sensor spi block
// assumes: master model in asspi_master_model.sv, short nvm counts
`timescale 1ns/1ns
`include "asspi_map.svh"
module testbench import asspi_pkg::*; ;
    localparam int unsigned ONE = 400;
    localparam int unsigned ALL = 800;
    localparam int unsigned RES = 300;
    localparam int unsigned FR = 206; // sys_clk cycles per master frame
    logic sys_clk, rst_n, sclk, cs_n, mosi, miso, miso_oe, fh, fl, nvm_busy, dir_ccw, ccw;
    logic [15:0] angle_in, rx, ea;
    logic [31:0] lfsr;
    int num_errors, n_tests;

    asspi_top #(.STORE_ONE_CYC(ONE), .STORE_ALL_CYC(ALL), .RESTORE_CYC(RES)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .angle_in(angle_in), .field_high_flag(fh),
        .field_low_flag(fl), .nvm_busy(nvm_busy), .dir_ccw(dir_ccw));
    asspi_master_model i_master (
        .sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // reversed sense reports the two's complement of the angle
    function automatic logic [15:0] exp_angle(input logic [15:0] a, input logic c);
        return c ? 16'h0000 - a : a;
    endfunction : exp_angle

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic frame(input logic [2:0] op, input logic [4:0] a, input logic [7:0] d);
        i_master.xfer({op, a, d}, 16, rx);
    endtask : frame

    // two-frame register write and read; rx ends as the reply frame
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        frame(`ASSPI_OP_WRITE, a, d);
        frame(`ASSPI_OP_ANGLE, 5'h00, 8'h00);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        frame(`ASSPI_OP_READ, a, 8'h00);
        frame(`ASSPI_OP_ANGLE, 5'h00, 8'h00);
    endtask : rd

    task automatic nv(input logic [2:0] op, input logic [4:0] a);
        frame(op, a, 8'h00);
        chk(rx, exp_angle(angle_in, ccw));
    endtask : nv

    // busy counted from just after the command frame; bounded wait
    task automatic nvwait(input int unsigned len);
        int n;
        n = 0;
        while (nvm_busy === 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        chk((n + 30 >= len && n <= len + 2) ? 32'h1 : 32'h0, 32'h1);
    endtask : nvwait

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // watchdog: the sequence needs about 16000 cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        test_done;
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        angle_in = 16'h1234;
        fh = 1'b0;
        fl = 1'b0;
        ccw = 1'b0;
        lfsr = 32'hA7E1291B;
        num_errors = 0;
        n_tests = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        chk(nvm_busy, 1'b0);
        chk(miso_oe, 1'b0);
        // random angle, direction and flags through every register path
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            angle_in <= lfsr[15:0];
            ccw = lfsr[16];
            fh <= lfsr[17];
            fl <= lfsr[18];
            wr(`ASSPI_REG_DIR, {ccw, 7'h00});
            ea = exp_angle(angle_in, ccw);
            chk(rx, {ea[15:8], ccw, 7'h00});
            chk(dir_ccw, ccw);
            i_master.xfer(16'h0000, 16, rx);
            chk(rx, ea);
            rd(`ASSPI_REG_DIR);
            chk(rx, {ea[15:8], ccw, 7'h00});
            rd(`ASSPI_REG_FIELD);
            chk(rx, {ea[15:8], lfsr[17], lfsr[18], 6'h00});
        end
        // read-only flags ignore a write
        wr(`ASSPI_REG_FIELD, 8'h3F);
        rd(`ASSPI_REG_FIELD);
        chk(rx[7:0], {fh, fl, 6'h00});
        $display("done: register and angle paths");
        // early stop, short frame dropped, buffer frozen while selected
        angle_in <= 16'hA5C3;
        ea = exp_angle(16'hA5C3, ccw);
        i_master.xfer(16'h0000, 8, rx);
        chk(rx[7:0], ea[15:8]);
        i_master.xfer({`ASSPI_OP_WRITE, `ASSPI_REG_DIR, ~ccw, 7'h7F}, 8, rx);
        rd(`ASSPI_REG_DIR);
        chk(rx[7:0], {ccw, 7'h00});
        fork
            i_master.xfer(16'h0000, 16, rx);
            begin
                repeat (100) @(posedge sys_clk);
                angle_in <= 16'h5A3C;
            end
        join
        chk(rx, ea);
        i_master.xfer(16'h0000, 16, rx);
        chk(rx, exp_angle(16'h5A3C, ccw));
        $display("done: framing and freeze");
        // store one, overwrite, restore brings it back
        wr(`ASSPI_REG_DIR, 8'h80);
        ccw = 1'b1;
        nv(`ASSPI_OP_STORE_ONE, `ASSPI_REG_DIR);
        nvwait(ONE);
        wr(`ASSPI_REG_DIR, 8'h00);
        ccw = 1'b0;
        nv(`ASSPI_OP_RESTORE, 5'h00);
        nvwait(RES);
        ccw = 1'b1;
        rd(`ASSPI_REG_DIR);
        chk(rx[7:0], 8'h80);
        // store all, a write refused while busy, restore
        wr(`ASSPI_REG_DIR, 8'h00);
        ccw = 1'b0;
        nv(`ASSPI_OP_STORE_ALL, 5'h00);
        wr(`ASSPI_REG_DIR, 8'h80);
        chk(rx, exp_angle(angle_in, ccw));
        nvwait(ALL - 2 * FR);
        chk(dir_ccw, 1'b0);
        wr(`ASSPI_REG_DIR, 8'h80);
        ccw = 1'b1;
        nv(`ASSPI_OP_RESTORE, 5'h00);
        nvwait(RES);
        ccw = 1'b0;
        rd(`ASSPI_REG_DIR);
        chk(rx[7:0], 8'h00);
        chk(dir_ccw, 1'b0);
        $display("done: nonvolatile commands");
        // second reset loads the stored image
        wr(`ASSPI_REG_DIR, 8'h80);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rd(`ASSPI_REG_DIR);
        chk(rx[7:0], 8'h00);
        $display("done: start-up load");
        test_done;
    end
endmodule : testbench
